// *** core/pld_channel.sv ***
`timescale 1ns/1ns
`default_nettype none
module pld_channel #(
  parameter int DUTY_W = 8,
  parameter int CNT_W  = 12
) (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  // timebase
  input  wire logic              tick_i,
  input  wire logic [CNT_W-1:0]  cnt_i,
  input  wire logic              slow_i,
  // duty
  input  wire logic [DUTY_W-1:0] duty_buf_i,
  output logic      [DUTY_W-1:0] active_o,
  // pin
  output logic                   pulse_o
);

  logic [DUTY_W-1:0] step;
  logic              last;

  // slow mode uses the upper count bits: 16 timer ticks per step
  assign step = slow_i ? cnt_i[CNT_W-1:CNT_W-DUTY_W] : cnt_i[DUTY_W-1:0]; // RQ7 RQ9
  assign last = slow_i ? (&cnt_i) : (&cnt_i[DUTY_W-1:0]); // RQ5 RQ6

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      active_o <= '0; // RQ12
    end else if (tick_i && last) begin
      active_o <= duty_buf_i; // RQ4
    end
  end

  // frozen when no tick, counter clear or slow_i change arrives, since count, slow_i and active all hold
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pulse_o <= 1'b0;
    end else begin
      pulse_o <= (active_o != '0) && (step < active_o); // RQ2 RQ3 RQ17
    end
  end

endmodule : pld_channel
`default_nettype wire

// *** core/pld_dac_top.sv ***
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
`include "pld_defs.svh"
module pld_dac_top #(
  parameter int TIMER_W = `PLD_TIMER_W
) (
  // clock and reset
  input  wire logic        SYS_CLK_I,
  input  wire logic        RESETN_I,
  // wishbone slave
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  // power control from the core
  input  wire logic        HALT_ENTER_I,
  input  wire logic        WAKE_IRQ_I,
  // timer counter control
  input  wire logic        TIMER_CNT_RST_I,
  // pins
  output logic             PULSE_OUT_A_O,
  output logic             PULSE_OUT_B_O,
  // system state
  output logic             SYSTEM_SLOW_O,
  output logic             HALTED_O
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  pld_pkg::pld_pwr_t  pwr_ff;
  pld_pkg::pld_pwr_t  nxt_pwr;
  pld_pkg::pld_duty_t len_a_ff;
  pld_pkg::pld_duty_t len_b_ff;
  pld_pkg::pld_duty_t act_a;
  pld_pkg::pld_duty_t act_b;
  logic               speed_sel_a_ff;
  logic               speed_sel_b_ff;
  logic               system_slow_ff;
  logic [TIMER_W-1:0] timer_cnt_ff;
  logic               timer_tick;
  logic               pulse_a;
  logic               pulse_b;
  logic               run;
  logic               acc;
  logic               wr;
  logic               wr_lo;
  logic [5:0]         idx;
  logic [31:0]        nxt_rdata;
  logic [7:0]         misc_rd;
  logic [31:0]        stat_rd;
  logic               wr_len_a;
  logic               wr_len_b;
  logic               wr_misc;
  logic               halt_req;
  logic               chan_tick;
  logic [11:0]        chan_cnt;

  ////////////////////////////////////////////////////////////////////////////
  // wishbone decode

  // one access per cycle pair: ack drops the cycle after it is given
  assign acc   = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign wr    = acc && WB_WE_I;
  assign wr_lo = wr && WB_SEL_I[0];
  assign idx   = WB_ADR_I[7:2];

  // one strobe per register keeps the write decode in one place
  assign wr_len_a = wr_lo && (idx == `PLD_IDX_LEN_A);
  assign wr_len_b = wr_lo && (idx == `PLD_IDX_LEN_B);
  assign wr_misc  = wr_lo && (idx == `PLD_IDX_MISC);

  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      WB_ACK_O <= 1'b0;
    end else begin
      WB_ACK_O <= acc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power state

  assign run      = (pwr_ff == pld_pkg::PWR_RUN);
  assign halt_req = run && HALT_ENTER_I;

  // light idle is not an input here: the block ignores it entirely
  always_comb begin
    nxt_pwr = pwr_ff;
    unique case (pwr_ff)
      pld_pkg::PWR_RUN: begin
        if (HALT_ENTER_I) begin
          nxt_pwr = pld_pkg::PWR_HALT; // RQ14
        end
      end
      pld_pkg::PWR_HALT: begin
        if (WAKE_IRQ_I) begin
          nxt_pwr = pld_pkg::PWR_RUN; // RQ14
        end
      end
    endcase
  end

  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      pwr_ff <= pld_pkg::PWR_RUN;
    end else begin
      pwr_ff <= nxt_pwr;
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      HALTED_O <= 1'b0;
    end else begin
      HALTED_O <= (nxt_pwr == pld_pkg::PWR_HALT);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // duty holding registers

  // bus writes land here; the channel copies them only at period end
  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      len_a_ff <= `PLD_RST_DUTY; // RQ12
    end else if (wr_len_a) begin
      len_a_ff <= WB_DAT_I[7:0]; // RQ4
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      len_b_ff <= `PLD_RST_DUTY; // RQ12
    end else if (wr_len_b) begin
      len_b_ff <= WB_DAT_I[7:0]; // RQ4
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // misc control

  // speed bits go straight to the channels, no second stage
  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      speed_sel_a_ff <= `PLD_RST_BIT;
    end else if (wr_misc) begin
      speed_sel_a_ff <= WB_DAT_I[`PLD_BIT_SPEED_A]; // RQ5 RQ10
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      speed_sel_b_ff <= `PLD_RST_BIT;
    end else if (wr_misc) begin
      speed_sel_b_ff <= WB_DAT_I[`PLD_BIT_SPEED_B]; // RQ6 RQ10
    end
  end

  // halt entry beats a write in the same cycle
  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      system_slow_ff <= `PLD_RST_BIT; // RQ16
    end else if (halt_req) begin
      system_slow_ff <= 1'b0; // RQ16
    end else if (wr_misc) begin
      system_slow_ff <= WB_DAT_I[`PLD_BIT_SLOW]; // RQ15
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      SYSTEM_SLOW_O <= 1'b0;
    end else begin
      SYSTEM_SLOW_O <= system_slow_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timebase

  pld_tick_gen #(
    .SM_DIV    (`PLD_SM_DIV),
    .TIMER_DIV (`PLD_TIMER_DIV)
  ) u_tick (
    .clk_i        (SYS_CLK_I),
    .rst_n_i      (RESETN_I),
    .run_i        (run),
    .slow_i       (system_slow_ff),
    .timer_tick_o (timer_tick)
  );

  // shared with the programmable timer; clearing it cuts both periods short
  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      timer_cnt_ff <= '0;
    end else if (TIMER_CNT_RST_I) begin
      timer_cnt_ff <= '0; // RQ11
    end else if (timer_tick) begin
      timer_cnt_ff <= timer_cnt_ff + 1'b1; // RQ8 RQ11
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // channels

  // a counter clear swallows that tick, so no reload on a cut period
  assign chan_tick = timer_tick && !TIMER_CNT_RST_I; // RQ11
  assign chan_cnt  = timer_cnt_ff[11:0];

  pld_channel #(
    .DUTY_W (8),
    .CNT_W  (12)
  ) u_chan_a (
    .clk_i      (SYS_CLK_I),
    .rst_n_i    (RESETN_I),
    .tick_i     (chan_tick),
    .cnt_i      (chan_cnt),
    .slow_i     (speed_sel_a_ff),
    .duty_buf_i (len_a_ff),
    .active_o   (act_a),
    .pulse_o    (pulse_a)
  ); // RQ1

  pld_channel #(
    .DUTY_W (8),
    .CNT_W  (12)
  ) u_chan_b (
    .clk_i      (SYS_CLK_I),
    .rst_n_i    (RESETN_I),
    .tick_i     (chan_tick),
    .cnt_i      (chan_cnt),
    .slow_i     (speed_sel_b_ff),
    .duty_buf_i (len_b_ff),
    .active_o   (act_b),
    .pulse_o    (pulse_b)
  ); // RQ1

  // extra stage keeps pins on top-level flops; adds one clock of lag
  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      PULSE_OUT_A_O <= 1'b0; // RQ12
    end else begin
      PULSE_OUT_A_O <= pulse_a; // RQ13
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      PULSE_OUT_B_O <= 1'b0; // RQ12
    end else begin
      PULSE_OUT_B_O <= pulse_b; // RQ13
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read back

  always_comb begin
    misc_rd                    = 8'h00;
    misc_rd[`PLD_BIT_SPEED_A]  = speed_sel_a_ff;
    misc_rd[`PLD_BIT_SPEED_B]  = speed_sel_b_ff;
    misc_rd[`PLD_BIT_SLOW]     = system_slow_ff;
  end

  always_comb begin
    stat_rd                                         = 32'h0000_0000;
    stat_rd[`PLD_STAT_ACT_A_LSB +: 8]               = act_a;
    stat_rd[`PLD_STAT_ACT_B_LSB +: 8]               = act_b;
    stat_rd[`PLD_BIT_STAT_HALT]                     = !run;
  end

  // unmapped offsets still ack, reading zero and ignoring writes
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    unique case (idx)
      `PLD_IDX_LEN_A: nxt_rdata = {24'h00_0000, len_a_ff};
      `PLD_IDX_LEN_B: nxt_rdata = {24'h00_0000, len_b_ff};
      `PLD_IDX_MISC:  nxt_rdata = {24'h00_0000, misc_rd};
      `PLD_IDX_STAT:  nxt_rdata = stat_rd;
      default:        nxt_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      WB_DAT_O <= 32'h0000_0000;
    end else if (acc && !WB_WE_I) begin
      WB_DAT_O <= nxt_rdata;
    end
  end

endmodule : pld_dac_top
`default_nettype wire

// *** core/pld_tick_gen.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "pld_defs.svh"
module pld_tick_gen #(
  parameter int SM_DIV    = `PLD_SM_DIV,
  parameter int TIMER_DIV = `PLD_TIMER_DIV
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // control
  input  wire logic run_i,
  input  wire logic slow_i,
  // tick
  output logic      timer_tick_o
);

  logic [$clog2(SM_DIV)-1:0]    cpu_cnt_ff;
  logic [$clog2(TIMER_DIV)-1:0] tmr_cnt_ff;
  logic                         cpu_tick;

  // halt stops the oscillator, so no tick at all
  assign cpu_tick = run_i && (!slow_i ||
                    (cpu_cnt_ff == ($clog2(SM_DIV))'(SM_DIV - 1))); // RQ15 RQ14

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cpu_cnt_ff <= '0;
    end else if (run_i) begin
      cpu_cnt_ff <= cpu_cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tmr_cnt_ff <= '0;
    end else if (cpu_tick) begin
      tmr_cnt_ff <= tmr_cnt_ff + 1'b1; // RQ8
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      timer_tick_o <= 1'b0;
    end else begin
      timer_tick_o <= cpu_tick &&
                      (tmr_cnt_ff == ($clog2(TIMER_DIV))'(TIMER_DIV - 1)); // RQ8
    end
  end

endmodule : pld_tick_gen
`default_nettype wire

// *** include/pld_defs.svh ***
`ifndef PLD_DEFS_SVH
`define PLD_DEFS_SVH
// Operation
// (RQ1) two independent channels, each an 8-bit duty value driving its own pin
// (RQ2) duty zero keeps that pin low for the whole period
// (RQ3) nonzero duty N keeps the pin high for N/256 of each period
// (RQ4) written duty reaches the comparator only at the end of a full period
// (RQ5) channel A speed bit: set gives 4096 timer ticks, clear gives 256
// (RQ6) channel B speed bit: set gives 4096 timer ticks, clear gives 256
// (RQ7) one duty step is 4 CPU clocks fast, 64 CPU clocks slow
// (RQ8) timer clock pacing both channels is the CPU clock divided by four
// (RQ9) speed change alters period length only, resolution stays 256 steps
// (RQ10) software sets speed bits before writing duty; speed bits act at once
// (RQ11) period count comes from the timer counter; its reset disturbs both outputs
// (RQ12) power-on or external reset clears both duty values, outputs stay low
// (RQ13) light idle mode leaves both waveforms running unchanged
// (RQ14) halt freezes each output level; interrupt wake resumes modulation
// (RQ15) system slow bit runs the bus clock, and timer, 16 times slower; here only the CPU tick and timer slow, the bus stays on SYS_CLK_I
// (RQ16) system slow bit cleared by reset and on halt entry
// (RQ17) output high from period start when duty nonzero, low once step reaches duty

// register indices; byte address is four times the index
`define PLD_IDX_LEN_A     6'h0A
`define PLD_IDX_LEN_B     6'h0B
`define PLD_IDX_MISC      6'h0C
`define PLD_IDX_STAT      6'h0D

// misc control fields
`define PLD_BIT_SPEED_A   3
`define PLD_BIT_SPEED_B   2
`define PLD_BIT_SLOW      1

// status fields
`define PLD_STAT_ACT_A_LSB 0
`define PLD_STAT_ACT_B_LSB 8
`define PLD_BIT_STAT_HALT  16

// reset values
`define PLD_RST_DUTY      8'h00
`define PLD_RST_BIT       1'b0

// timing counts
`define PLD_SM_DIV        16
`define PLD_TIMER_DIV     4
`define PLD_FAST_TICKS    256
`define PLD_SLOW_TICKS    4096
`define PLD_TIMER_W       16

`endif

// *** include/pld_pkg.sv ***
package pld_pkg;

  typedef enum logic {
    PWR_RUN,
    PWR_HALT
  } pld_pwr_t;

  typedef logic [7:0] pld_duty_t;

endpackage : pld_pkg

// *** tb/pld_dac_checker.sv ***
`timescale 1ns/1ns
`default_nettype none
module pld_dac_checker (
  // clock and reset
  input wire logic SYS_CLK_I,
  input wire logic RESETN_I,
  // bus
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_ACK_O,
  // power
  input wire logic HALT_ENTER_I,
  input wire logic WAKE_IRQ_I,
  input wire logic HALTED_O,
  input wire logic SYSTEM_SLOW_O,
  // pins
  input wire logic PULSE_OUT_A_O,
  input wire logic PULSE_OUT_B_O
);
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!RESETN_I);
  wire logic req = WB_CYC_I && WB_STB_I;
  ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack held too long");
  ack_answer_a: assert property (req && !WB_ACK_O |=> WB_ACK_O) else $error("ack missing");
  ack_cause_a: assert property (WB_ACK_O |-> $past(req)) else $error("ack without request");
  halt_enter_a: assert property (HALT_ENTER_I && !HALTED_O && !WAKE_IRQ_I |-> ##[1:2] HALTED_O)
    else $error("halt not entered");
  halt_wake_a: assert property (WAKE_IRQ_I && HALTED_O |-> ##[1:2] !HALTED_O)
    else $error("wake ignored");
  slow_clear_a: assert property ($rose(HALTED_O) |-> ##[0:2] !SYSTEM_SLOW_O)
    else $error("slow bit kept in halt");
  // margin of six covers the counter to pin pipeline
  halt_freeze_a: assert property (HALTED_O && $past(HALTED_O, 6)
    |-> $stable(PULSE_OUT_A_O) && $stable(PULSE_OUT_B_O)) else $error("pin moved in halt");
  reset_low_a: assert property ($rose(RESETN_I)
    |-> (!PULSE_OUT_A_O && !PULSE_OUT_B_O)[*8]) else $error("pin high after reset");
  cover property (req && WB_ACK_O);
  cover property ($rose(HALTED_O));
  cover property ($rose(PULSE_OUT_A_O));
  cover property ($rose(SYSTEM_SLOW_O));
endmodule : pld_dac_checker
bind pld_dac_top pld_dac_checker i_pld_dac_checker (
  .SYS_CLK_I(SYS_CLK_I), .RESETN_I(RESETN_I), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_ACK_O(WB_ACK_O), .HALT_ENTER_I(HALT_ENTER_I), .WAKE_IRQ_I(WAKE_IRQ_I),
  .HALTED_O(HALTED_O), .SYSTEM_SLOW_O(SYSTEM_SLOW_O), .PULSE_OUT_A_O(PULSE_OUT_A_O),
  .PULSE_OUT_B_O(PULSE_OUT_B_O));
`default_nettype wire

// *** tb/pld_dac_top_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
module pld_dac_top_bench;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic        halt = 1'b0, wake = 1'b0, trst = 1'b0, clr = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h0, dat_o, q;
  logic        ack, pa, pb, slw, hlt;
  int          ha, ua, hb, ub;
  int          err_count = 0;
  int          num_checks = 0;
  always #5 clk = ~clk;
  pld_dac_top i_pld_dac_top (.SYS_CLK_I(clk), .RESETN_I(rst_n), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat),
    .WB_DAT_O(dat_o), .WB_ACK_O(ack), .HALT_ENTER_I(halt), .WAKE_IRQ_I(wake),
    .TIMER_CNT_RST_I(trst), .PULSE_OUT_A_O(pa), .PULSE_OUT_B_O(pb),
    .SYSTEM_SLOW_O(slw), .HALTED_O(hlt));
  pld_load_model i_pld_load_model (.clk_i(clk), .clr_i(clr), .pin_a_i(pa), .pin_b_i(pb),
    .hi_a_o(ha), .up_a_o(ua), .hi_b_o(hb), .up_b_o(ub));
  //////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      $display("[ERR] %s exp %0h got %0h", nm, e, g);
      err_count++;
    end
  endtask : chk
  // classic cycle; caller stands just after a rising edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    chk("ack", 32'h1, ack);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : wb
  // whole periods only, so the alignment of the window drops out
  task automatic meas(input int n, input int ea, input int eua, input int eb, input int eub);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (n + 1) @(posedge clk);
    if (ea >= 0) chk("high a", ea, ha);
    chk("rise a", eua, ua);
    if (eb >= 0) chk("high b", eb, hb);
    chk("rise b", eub, ub);
  endtask : meas
  task automatic wact(input logic [15:0] v, input int lim);
    int n;
    n = 0;
    do begin
      wb(1'b0, 8'h34, 32'h0, 4'hF);
      n++;
    end while (q[15:0] !== v && n < lim);
    chk("active duty", {16'h0, v}, {16'h0, q[15:0]});
  endtask : wact
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    for (int i = 0; i < 5; i++) begin
      wb(1'b0, 8'h28 + 8'(4 * i), 32'h0, 4'hF);
      chk("reset value", 32'h0, q);
    end
    wb(1'b1, 8'h28, 32'h55, 4'hE);
    wb(1'b1, 8'h3C, 32'hFF, 4'hF);
    wb(1'b0, 8'h28, 32'h0, 4'hF);
    chk("lane off write", 32'h0, q);
    wb(1'b1, 8'h30, 32'hFF, 4'hF);
    wb(1'b0, 8'h30, 32'h0, 4'hF);
    chk("misc bits", 32'h0E, q);
    wb(1'b1, 8'h30, 32'h0, 4'hF);
  endtask : t_regs
  task automatic t_duty();
    logic [7:0]  tab [4] = '{8'h00, 8'h01, 8'h80, 8'hFF};
    logic [7:0]  a;
    logic [15:0] old;
    old = 16'h0;
    for (int i = 0; i < 4; i++) begin
      a = tab[i];
      wb(1'b1, 8'h28, {24'h0, a}, 4'h1);
      wb(1'b1, 8'h2C, {24'h0, ~a}, 4'h1);
      wb(1'b0, 8'h34, 32'h0, 4'hF);
      chk("held duty", {16'h0, old}, {16'h0, q[15:0]});
      old = {~a, a};
      wact(old, 400);
      meas(1024, 4 * a, a != 0, 4 * (255 - a), a != 8'hFF);
    end
  endtask : t_duty
  task automatic t_speed();
    wb(1'b1, 8'h30, 32'h08, 4'h1);
    wb(1'b1, 8'h28, 32'h40, 4'h1);
    wb(1'b1, 8'h2C, 32'h20, 4'h1);
    wact(16'h2040, 6000);
    meas(16384, 4096, 1, 2048, 16);
    wb(1'b1, 8'h30, 32'h04, 4'h1);
    meas(16384, 4096, 16, 2048, 1);
  endtask : t_speed
  task automatic t_sys_halt();
    wb(1'b1, 8'h30, 32'h02, 4'h1);
    chk("slow out", 32'h1, slw);
    // first slowed tick may lag; window must see a steady tick train
    repeat (128) @(posedge clk);
    meas(16384, 4096, 1, 2048, 1);
    halt <= 1'b1;
    @(posedge clk);
    halt <= 1'b0;
    repeat (3) @(posedge clk);
    chk("halted", 32'h1, hlt);
    chk("slow cleared", 32'h0, slw);
    wb(1'b0, 8'h30, 32'h0, 4'hF);
    chk("misc in halt", 32'h0, q[7:0]);
    meas(300, -1, 0, -1, 0);
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    repeat (3) @(posedge clk);
    chk("woken", 32'h0, hlt);
    repeat (16) @(posedge clk);
    meas(1024, 256, 1, 128, 1);
  endtask : t_sys_halt
  task automatic t_trst();
    trst <= 1'b1;
    repeat (8) @(posedge clk);
    meas(200, 200, 0, 200, 0);
    trst <= 1'b0;
    @(posedge clk);
  endtask : t_trst
  task automatic t_reset();
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    wb(1'b0, 8'h34, 32'h0, 4'hF);
    chk("status after reset", 32'h0, q);
    meas(1024, 0, 0, 0, 0);
  endtask : t_reset
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_duty();
    t_speed();
    t_sys_halt();
    t_trst();
    t_reset();
    stop_test();
  end
  // run needs some 70k cycles
  initial begin
    #990000;
    err_count++;
    stop_test();
  end
endmodule : pld_dac_top_bench
`default_nettype wire

// *** tb/pld_load_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module pld_load_model (
  // clock and window clear
  input  wire logic clk_i,
  input  wire logic clr_i,
  // pins
  input  wire logic pin_a_i,
  input  wire logic pin_b_i,
  // integrated high time and rising edges
  output var int    hi_a_o,
  output var int    up_a_o,
  output var int    hi_b_o,
  output var int    up_b_o
);
  // ideal averager; edge count tells the period apart from the duty
  logic prev_a;
  logic prev_b;
  always_ff @(posedge clk_i) begin
    prev_a <= pin_a_i;
    prev_b <= pin_b_i;
    if (clr_i) begin
      hi_a_o <= 0;
      up_a_o <= 0;
      hi_b_o <= 0;
      up_b_o <= 0;
    end else begin
      hi_a_o <= hi_a_o + int'(pin_a_i === 1'b1);
      up_a_o <= up_a_o + int'(pin_a_i === 1'b1 && prev_a === 1'b0);
      hi_b_o <= hi_b_o + int'(pin_b_i === 1'b1);
      up_b_o <= up_b_o + int'(pin_b_i === 1'b1 && prev_b === 1'b0);
    end
  end
endmodule : pld_load_model
`default_nettype wire
